//--- rtl/drt_pkg.sv
// Purpose: constants for the dual reload timer
// Assumes: classic wishbone, 32-bit data, one register per word
// Notes: printed offsets are not all multiples of four, so byte address is index * 4
package drt_pkg;
	localparam int REG_W = 8;
	// register indices as printed; byte address = index * 4
	localparam logic [15:0] IDX_MODE = 16'h100C;
	localparam logic [15:0] IDX_T0_RELOAD = 16'h100D;
	localparam logic [15:0] IDX_T0_COUNT = 16'h100E;
	localparam logic [15:0] IDX_T1_RELOAD = 16'h100F;
	localparam logic [15:0] IDX_T1_COUNT = 16'h1010;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'h1011;
	localparam logic [15:0] IDX_IRQ_MASK = 16'h1012;
	// mode register fields
	localparam int T0_PRE_LSB = 0;
	localparam int T0_EN_BIT = 3;
	localparam int T1_PRE_LSB = 4;
	localparam int T1_SRC_BIT = 6;
	localparam int T1_EN_BIT = 7;
	// interrupt status fields
	localparam int IRQ_T0_BIT = 0;
	localparam int IRQ_T1_BIT = 1;
	localparam logic [7:0] RST_REG = 8'h00;
	// prescaler divide exponents (divide = 2**exp)
	localparam int PRE_CNT_W = 14;
	localparam logic [2:0] T0_STEP_EXP = 3'h2;
	localparam logic [3:0] T1_EXP_DIV8 = 4'h3;
	localparam logic [3:0] T1_EXP_DIV64 = 4'h6;
	localparam logic [3:0] T1_EXP_DIV1024 = 4'hA;
endpackage : drt_pkg

//--- rtl/drt_prescaler.sv
// Purpose: free-running power-of-two prescaler producing a one-cycle tick enable
// Assumes: src_en_i is a one-cycle enable in clk_i domain, high on each source edge
// Notes: exponent 0 passes the source enable through, registered one cycle later
`timescale 1ns/10ps
module drt_prescaler #(
	parameter int CNT_W = 14
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic src_en_i,
	input wire logic [3:0] exp_i,
	output logic tick_o
);
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] mask;
	logic next_tick;

	always_comb begin
		mask = CNT_W'((CNT_W'(1) << exp_i) - CNT_W'(1));
		next_cnt = cnt;
		next_tick = 1'b0;
		if (src_en_i) begin
			if ((cnt & mask) == mask) begin
				next_cnt = '0;
				next_tick = 1'b1;
			end else begin
				next_cnt = CNT_W'(cnt + CNT_W'(1));
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick_o <= next_tick;
		end
	end
endmodule // drt_prescaler

//--- rtl/drt_timer.sv
// Purpose: two 8-bit up-counting reload timers behind a classic wishbone slave
// Assumes: base_clk_en_i is a one-cycle enable in clk_i domain per base clock edge
// Notes: status register clears on read; a same-cycle event wins over the clear
//
// Functional notes
// - two independent timers, each prescaler plus 8-bit up-counter plus 8-bit reload
// - mode bits 2..0 divide system clock by 1,4,16,64,256,1024,4096,16384
// - mode bit 6 picks timer 1 source: 1 system clock, 0 base clock
// - mode bits 5..4 divide timer 1 source by 1,8,64,1024
// - mode bit 7 enables timer 1 counting
// - mode bit 3 enables timer 0 counting
// - timer 0 reaching reload clears to zero and sets its interrupt status
// - timer 1 reaching reload clears to zero and sets its interrupt status
// - writing timer 0 count loads it; reading returns present count
// - writing timer 1 count loads it; reading returns present count
// - reload registers are read/write and hold the wrap compare value
`timescale 1ns/10ps
module drt_timer #(
	parameter int ADR_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic base_clk_unused_o,
	input wire logic base_clk_en_i,
	output logic irq_o,
	output logic t0_wrap_o,
	output logic t1_wrap_o
);
	// ***********************************************************
	// bus decode
	// ***********************************************************
	function automatic logic hit(input logic [ADR_W-1:0] a, input logic [15:0] idx);
		hit = (a[ADR_W-1:2] == (ADR_W-2)'(idx)) && (a[1:0] == 2'h0);
	endfunction

	logic req;
	logic wr;
	logic rd;
	assign req = cyc_i && stb_i && !ack_o;
	assign wr = req && we_i && sel_i[0];
	assign rd = req && !we_i;

	// ***********************************************************
	// registers
	// ***********************************************************
	logic [7:0] mode;
	logic [7:0] t0_reload;
	logic [7:0] t1_reload;
	logic [7:0] t0_cnt;
	logic [7:0] t1_cnt;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic [7:0] next_mode;
	logic [7:0] next_t0_reload;
	logic [7:0] next_t1_reload;
	logic [7:0] next_t0_cnt;
	logic [7:0] next_t1_cnt;
	logic [1:0] next_irq_stat;
	logic [1:0] next_irq_mask;
	logic [31:0] next_dat;
	logic next_t0_wrap;
	logic next_t1_wrap;

	// ***********************************************************
	// prescalers
	// ***********************************************************
	logic t0_tick;
	logic t1_tick;
	logic t1_src_en;
	logic [3:0] t0_exp;
	logic [3:0] t1_exp;

	always_comb begin
		// timer 0 step is divide-by-4 per code
		t0_exp = 4'({1'b0, mode[drt_pkg::T0_PRE_LSB +: 3]} * 4'(drt_pkg::T0_STEP_EXP));
		case (mode[drt_pkg::T1_PRE_LSB +: 2])
			2'h0: t1_exp = 4'h0;
			2'h1: t1_exp = drt_pkg::T1_EXP_DIV8;
			2'h2: t1_exp = drt_pkg::T1_EXP_DIV64;
			2'h3: t1_exp = drt_pkg::T1_EXP_DIV1024;
			default: t1_exp = 4'h0;
		endcase
		t1_src_en = mode[drt_pkg::T1_SRC_BIT] ? 1'b1 : base_clk_en_i;
	end

	// prescalers run freely; the tick output lags its source by one cycle
	drt_prescaler #(.CNT_W(drt_pkg::PRE_CNT_W)) u_pre0 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.src_en_i(1'b1),
		.exp_i(t0_exp),
		.tick_o(t0_tick)
	);

	drt_prescaler #(.CNT_W(drt_pkg::PRE_CNT_W)) u_pre1 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.src_en_i(t1_src_en),
		.exp_i(t1_exp),
		.tick_o(t1_tick)
	);

	// ***********************************************************
	// next state
	// ***********************************************************
	always_comb begin
		next_mode = mode;
		next_t0_reload = t0_reload;
		next_t1_reload = t1_reload;
		next_t0_cnt = t0_cnt;
		next_t1_cnt = t1_cnt;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_t0_wrap = 1'b0;
		next_t1_wrap = 1'b0;
		next_dat = 32'h0000_0000;

		// counting; a software count write below overrides the step
		if (mode[drt_pkg::T0_EN_BIT] && t0_tick) begin
			if (t0_cnt == t0_reload) begin
				next_t0_cnt = 8'h00;
				next_t0_wrap = 1'b1;
			end else begin
				next_t0_cnt = 8'(t0_cnt + 8'h01);
			end
		end
		if (mode[drt_pkg::T1_EN_BIT] && t1_tick) begin
			if (t1_cnt == t1_reload) begin
				next_t1_cnt = 8'h00;
				next_t1_wrap = 1'b1;
			end else begin
				next_t1_cnt = 8'(t1_cnt + 8'h01);
			end
		end

		if (rd) begin
			if (hit(adr_i, drt_pkg::IDX_MODE)) begin
				next_dat = {24'h000000, mode};
			end else if (hit(adr_i, drt_pkg::IDX_T0_RELOAD)) begin
				next_dat = {24'h000000, t0_reload};
			end else if (hit(adr_i, drt_pkg::IDX_T0_COUNT)) begin
				next_dat = {24'h000000, t0_cnt};
			end else if (hit(adr_i, drt_pkg::IDX_T1_RELOAD)) begin
				next_dat = {24'h000000, t1_reload};
			end else if (hit(adr_i, drt_pkg::IDX_T1_COUNT)) begin
				next_dat = {24'h000000, t1_cnt};
			end else if (hit(adr_i, drt_pkg::IDX_IRQ_STATUS)) begin
				next_dat = {30'h00000000, irq_stat};
				next_irq_stat = 2'h0;
			end else if (hit(adr_i, drt_pkg::IDX_IRQ_MASK)) begin
				next_dat = {30'h00000000, irq_mask};
			end
		end

		if (wr) begin
			if (hit(adr_i, drt_pkg::IDX_MODE)) begin
				next_mode = dat_i[7:0];
			end else if (hit(adr_i, drt_pkg::IDX_T0_RELOAD)) begin
				next_t0_reload = dat_i[7:0];
			end else if (hit(adr_i, drt_pkg::IDX_T0_COUNT)) begin
				next_t0_cnt = dat_i[7:0];
			end else if (hit(adr_i, drt_pkg::IDX_T1_RELOAD)) begin
				next_t1_reload = dat_i[7:0];
			end else if (hit(adr_i, drt_pkg::IDX_T1_COUNT)) begin
				next_t1_cnt = dat_i[7:0];
			end else if (hit(adr_i, drt_pkg::IDX_IRQ_MASK)) begin
				next_irq_mask = dat_i[1:0];
			end
		end

		// set wins over the read clear
		if (next_t0_wrap) begin
			next_irq_stat[drt_pkg::IRQ_T0_BIT] = 1'b1;
		end
		if (next_t1_wrap) begin
			next_irq_stat[drt_pkg::IRQ_T1_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= drt_pkg::RST_REG;
			t0_reload <= drt_pkg::RST_REG;
			t1_reload <= drt_pkg::RST_REG;
			t0_cnt <= drt_pkg::RST_REG;
			t1_cnt <= drt_pkg::RST_REG;
			irq_stat <= 2'h0;
			irq_mask <= 2'h0;
			dat_o <= 32'h0000_0000;
			ack_o <= 1'b0;
			irq_o <= 1'b0;
			t0_wrap_o <= 1'b0;
			t1_wrap_o <= 1'b0;
			base_clk_unused_o <= 1'b0;
		end else begin
			mode <= next_mode;
			t0_reload <= next_t0_reload;
			t1_reload <= next_t1_reload;
			t0_cnt <= next_t0_cnt;
			t1_cnt <= next_t1_cnt;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			dat_o <= next_dat;
			ack_o <= req;
			irq_o <= |(next_irq_stat & next_irq_mask);
			t0_wrap_o <= next_t0_wrap;
			t1_wrap_o <= next_t1_wrap;
			// low while timer 1 runs from the base clock and is enabled
			base_clk_unused_o <= !(next_mode[drt_pkg::T1_EN_BIT] && !next_mode[drt_pkg::T1_SRC_BIT]);
		end
	end
endmodule // drt_timer

//--- bench/drt_timer_props.sv
// Purpose: port-level checker for drt_timer
// Assumes: bound to every drt_timer instance
// Notes: sees ports only, so mode and status are judged through their effects
`timescale 1ns/10ps
module drt_timer_props #(
	parameter int ADR_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic base_clk_unused_o,
	input wire logic base_clk_en_i,
	input wire logic irq_o,
	input wire logic t0_wrap_o,
	input wire logic t1_wrap_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not answered");
	chk_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held");
	chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data outside ack");
	chk_dat_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_reset_quiet: assert property (disable iff (1'b0)
		rst_i |=> !irq_o && !t0_wrap_o && !t1_wrap_o && !ack_o) else $error("busy in reset");
	chk_irq_rise: assert property ($rose(irq_o) |-> t0_wrap_o || t1_wrap_o || ack_o || $past(ack_o))
		else $error("irq rose without cause");
	chk_irq_fall: assert property ($fell(irq_o) |-> ack_o || $past(ack_o))
		else $error("irq fell without access");
	cover property (t0_wrap_o);
	cover property (t1_wrap_o);
	cover property ($fell(irq_o));
endmodule // drt_timer_props
bind drt_timer drt_timer_props #(.ADR_W(ADR_W)) chk_u (.*);

//--- bench/tb_dual_reload_timer.sv
// Purpose: self-checking bench for drt_timer
// Assumes: base enable every third cycle
// Notes: periods measured on the third wrap, so prescaler phase cannot skew them
`timescale 1ns/10ps
module tb_dual_reload_timer;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic base_clk_en_i = 1'b0, ack_o, irq_o, t0_wrap_o, t1_wrap_o, bcu;
	logic [15:0] adr_i = 16'h0;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, q;
	int fails = 0, tests_run = 0, seed = 32'h4948152E, r, bcnt = 0;
	drt_timer dut_u (.base_clk_unused_o(bcu), .*);
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		bcnt <= (bcnt + 1) % 3;
		base_clk_en_i <= (bcnt == 2);
	end
	// ****
	// tasks
	// ****
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// k counts registers from the mode register; indices are consecutive
	task wb(input logic w, input int k, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, sel_i} <= {2'h3, w, 4'hF};
		adr_i <= (drt_pkg::IDX_MODE + 16'(k)) << 2;
		dat_i <= {24'h0, d};
		n = 0;
		// ack seen at the edge reads the registered value; release at that same edge
		do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin fails++; print_verdict; end
		q = dat_o;
		{cyc_i, stb_i} <= 2'h0;
	endtask
	task per(input logic s, input int e);
		int n;
		repeat (3) begin
			n = 0;
			do begin @(posedge clk_i); #1; n++; end
			while ((s ? t1_wrap_o : t0_wrap_o) !== 1'b1 && n < 40000);
			if (n >= 40000) begin fails++; print_verdict; end
		end
		cmp(32'(n), 32'(e));
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int k = 0; k < 7; k++) begin wb(0, k, 0); cmp(q, 0); end
		wb(1, 9, 8'hFF);
		wb(0, 9, 0); cmp(q, 0);
		for (int k = 1; k < 5; k++) begin
			r = $random(seed);
			wb(1, k, r[7:0]);
			wb(0, k, 0); cmp(q, {24'h0, r[7:0]});
		end
		r = $random(seed) & 7;
		wb(1, 1, r[7:0]);
		wb(1, 2, 0);
		wb(1, 0, 8'h08); per(0, r + 1);
		wb(1, 1, 0);
		for (int c = 1; c < 8; c++) begin wb(1, 0, 8'(8 | c)); per(0, 1 << (2 * c)); end
		wb(1, 3, 0);
		wb(1, 4, 0);
		for (int c = 0; c < 4; c++) begin
			wb(1, 0, 8'(8'hC0 | (c << 4)));
			per(1, c == 0 ? 1 : 1 << (3 * c + (c == 3)));
		end
		r = $random(seed) & 3;
		wb(1, 3, r[7:0]);
		wb(1, 0, 8'h80); per(1, 3 * (r + 1));
		cmp({31'h0, bcu}, 0);
		wb(1, 0, 0);
		cmp({31'h0, bcu}, 1);
		wb(0, 5, 0); cmp(q, 3);
		wb(0, 5, 0); cmp(q, 0);
		wb(1, 6, 1);
		wb(1, 0, 8'h08);
		wb(0, 5, 0); cmp(q, 1);
		cmp({31'h0, irq_o}, 1);
		wb(1, 0, 0);
		wb(0, 5, 0);
		wb(0, 5, 0); cmp(q, 0);
		cmp({31'h0, irq_o}, 0);
		wb(1, 6, 0);
		wb(1, 0, 8'h08);
		wb(0, 5, 0); cmp(q, 1);
		cmp({31'h0, irq_o}, 0);
		print_verdict;
	end
endmodule // tb_dual_reload_timer
